// ---- src/lnb_regulator_control_logic.sv ----
// Device end: serial slave, boost and tone timing, overcurrent shutdown.
`timescale 1ns/10ps
`include "lnb_ctrl_defines.svh"
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
module lnb_regulator_control_logic #(
  parameter int OcTimeoutTicks = `OC_TIMEOUT_TICKS
) (
  input  wire logic       clk,
  input  wire logic       srst,
  lnb_link_if.device      link,
  input  wire logic [1:0] addrSel,
  input  wire logic       toneGate,
  input  wire logic       currentLimitActive,
  input  wire logic       outputOverdrive,
  output logic            boostClk,
  output logic            toneOut,
  output logic            pullDownStrong,
  output logic            regulatorOn,
  output logic            overcurrentFaultFlag,
  output logic [7:0]      controlWord
);

  lnb_ctrl_pkg::dev_s q;
  lnb_ctrl_pkg::dev_s d;
  logic               sclRise;
  logic               sclFall;
  logic               startCond;
  logic               stopCond;
  logic               tick;
  logic               byteOk;
  logic [7:0]         ownAddr;

  // ----------------------------------------------------------------------
  // Edge and condition detection
  // ----------------------------------------------------------------------
  // Edges are taken from the second synchroniser stage and its delayed copy.
  assign sclRise   = q.sclS2 & ~q.sclP;
  assign sclFall   = ~q.sclS2 & q.sclP;
  assign startCond = q.sclS2 & q.sclP & ~q.sdaS2 & q.sdaP;
  assign stopCond  = q.sclS2 & q.sclP & q.sdaS2 & ~q.sdaP;
  assign tick      = (q.boostCnt == 8'(`BOOST_DIV_CYC - 1));
  assign ownAddr   = {`SLAVE_ADDR_HI, q.addrS2, 1'b0};

  always_comb begin
    case (q.byteIdx)
      2'h0:    byteOk = (q.shift == ownAddr);
      2'h1:    byteOk = (q.shift == `CTRL_REG_ADDR);
      2'h2:    byteOk = 1'b1;
      default: byteOk = 1'b0;
    endcase
  end

  always_comb begin
    d = q;
    d.sclS1  = link.scl;
    d.sclS2  = q.sclS1;
    d.sclP   = q.sclS2;
    d.sdaS1  = link.sda;
    d.sdaS2  = q.sdaS1;
    d.sdaP   = q.sdaS2;
    d.gateS1 = toneGate;
    d.gateS2 = q.gateS1;
    d.oclS1  = currentLimitActive;
    d.oclS2  = q.oclS1;
    d.ovrS1  = outputOverdrive;
    d.ovrS2  = q.ovrS1;
    d.addrS1 = addrSel;
    d.addrS2 = q.addrS1;

    // ----------------------------------------------------------------------
    // Serial slave
    // ----------------------------------------------------------------------
    if (startCond) begin
      d.st      = lnb_ctrl_pkg::DEV_RECV;
      d.bitCnt  = 4'h0;
      d.byteIdx = 2'h0;
      d.sdaOeN  = 1'b1;
    end else if (stopCond) begin
      d.st     = lnb_ctrl_pkg::DEV_IDLE;
      d.sdaOeN = 1'b1;
    end else begin
      case (q.st)
        lnb_ctrl_pkg::DEV_RECV: begin
          if (sclRise) begin
            d.shift  = {q.shift[6:0], q.sdaS2};
            d.bitCnt = q.bitCnt + 4'h1;
          end
          if (sclFall && q.bitCnt == `ACK_BIT_POS) begin
            if (byteOk) begin
              d.st     = lnb_ctrl_pkg::DEV_ACK;
              d.sdaOeN = 1'b0;
              if (q.byteIdx == 2'h2) begin
                d.ctrl = q.shift;
                if (q.shift[`CTRL_ENABLE_BIT]) begin
                  d.shutdown = 1'b0;
                  d.fault    = 1'b0;
                end
              end
            end else begin
              d.st = lnb_ctrl_pkg::DEV_IGNORE;
            end
          end
        end
        lnb_ctrl_pkg::DEV_ACK: begin
          if (sclFall) begin
            d.sdaOeN  = 1'b1;
            d.bitCnt  = 4'h0;
            d.byteIdx = q.byteIdx + 2'h1;
            d.st = (q.byteIdx == 2'h2) ? lnb_ctrl_pkg::DEV_IGNORE : lnb_ctrl_pkg::DEV_RECV;
          end
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------------
    // Boost and tone timing
    // ----------------------------------------------------------------------
    // Tone derived from sixteen boost periods.
    d.boostCnt = tick ? 8'h00 : q.boostCnt + 8'h01;
    if (tick) begin
      d.toneCnt = (q.toneCnt == 5'(`TONE_BOOST_RATIO - 1)) ? 5'h00 : q.toneCnt + 5'h01;
    end
    d.boostClk = (q.boostCnt < 8'(`BOOST_DIV_CYC / 2));
    d.toneOut = (q.toneCnt < 5'(`TONE_BOOST_RATIO / 2)) & q.gateS2;
    d.pullDownStrong = q.gateS2;

    // ----------------------------------------------------------------------
    // Overcurrent shutdown
    // ----------------------------------------------------------------------
    // The timeout sits after the serial commit so a fault in the same cycle
    // as a re-enable write still wins.
    if (!q.oclS2 || q.shutdown) begin
      d.ocCnt = 16'h0000;
    end else if (tick) begin
      if (q.ocCnt == 16'(OcTimeoutTicks)) begin
        d.shutdown = 1'b1;
        d.fault    = 1'b1;
        d.ocCnt    = 16'h0000;
      end else begin
        d.ocCnt = q.ocCnt + 16'h0001;
      end
    end
    d.regulatorOn = q.ctrl[`CTRL_ENABLE_BIT] & ~q.shutdown & ~q.ovrS2;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.st <= lnb_ctrl_pkg::DEV_IDLE;
      q.ctrl <= `CTRL_RESET;
      q.sdaOeN <= 1'b1;
      q.sclS1 <= 1'b1;
      q.sclS2 <= 1'b1;
      q.sclP <= 1'b1;
      q.sdaS1 <= 1'b1;
      q.sdaS2 <= 1'b1;
      q.sdaP <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Open-drain data only.
  assign link.sdaDevOut     = 1'b0;
  assign link.sdaDevOeN     = q.sdaOeN;
  assign boostClk           = q.boostClk;
  assign toneOut            = q.toneOut;
  assign pullDownStrong     = q.pullDownStrong;
  assign regulatorOn        = q.regulatorOn;
  assign overcurrentFaultFlag = q.fault;
  assign controlWord        = q.ctrl;

endmodule

// ---- src/lnb_ctrl_defines.svh ----
// Offsets, field positions, reset values and timing counts of the regulator control logic.
`ifndef LNB_CTRL_DEFINES_SVH
`define LNB_CTRL_DEFINES_SVH

// ----------------------------------------------------------------------
// Serial addressing
// ----------------------------------------------------------------------
`define SLAVE_ADDR_HI      5'h02
`define CTRL_REG_ADDR      8'h00
`define CTRL_RESET         8'h00
`define CTRL_ENABLE_BIT    0
`define ACK_BIT_POS        4'h8
`define FRAME_LAST_BIT     5'h1a

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_KHZ            20000
`define BOOST_KHZ          352
`define TONE_BOOST_RATIO   16
`define BOOST_DIV_CYC      (`CLK_KHZ / `BOOST_KHZ)
`define OC_TIMEOUT_MS      45
`define OC_TIMEOUT_TICKS   (`OC_TIMEOUT_MS * `BOOST_KHZ)
`define SCL_KHZ            100
`define SCL_QUARTER_CYC    (`CLK_KHZ / (`SCL_KHZ * 4))
`define RESTART_GAP_MS     1000
`define RESTART_GAP_CYC    (`RESTART_GAP_MS * `CLK_KHZ)

`endif

// ---- src/lnb_ctrl_pkg.sv ----
// Types shared by both ends of the regulator control link.
package lnb_ctrl_pkg;

  typedef enum logic [1:0] {DEV_IDLE, DEV_RECV, DEV_ACK, DEV_IGNORE} dev_state_e;
  typedef enum logic [2:0] {HOST_IDLE, HOST_START, HOST_BIT, HOST_STOP} host_state_e;

  typedef struct packed {
    logic       sclS1;
    logic       sclS2;
    logic       sclP;
    logic       sdaS1;
    logic       sdaS2;
    logic       sdaP;
    logic       gateS1;
    logic       gateS2;
    logic       oclS1;
    logic       oclS2;
    logic       ovrS1;
    logic       ovrS2;
    logic [1:0] addrS1;
    logic [1:0] addrS2;
    dev_state_e st;
    logic [3:0] bitCnt;
    logic [1:0] byteIdx;
    logic [7:0] shift;
    logic [7:0] ctrl;
    logic       sdaOeN;
    logic [7:0] boostCnt;
    logic [4:0] toneCnt;
    logic [15:0] ocCnt;
    logic       shutdown;
    logic       fault;
    logic       boostClk;
    logic       toneOut;
    logic       pullDownStrong;
    logic       regulatorOn;
  } dev_s;

  typedef struct packed {
    host_state_e st;
    logic [7:0]  qCnt;
    logic [1:0]  quarter;
    logic [26:0] frame;
    logic [4:0]  bitIdx;
    logic [3:0]  bitInByte;
    logic        nak;
    logic        enReq;
    logic        scl;
    logic        sdaOeN;
    logic        busy;
    logic        done;
    logic        acked;
    logic [24:0] gapCnt;
    logic        sdaS1;
    logic        sdaS2;
  } host_s;

endpackage

// ---- src/lnb_link_if.sv ----
// Two-wire link between the host master and the regulator slave.
`timescale 1ns/10ps
interface lnb_link_if;
  logic scl;
  logic sdaHostOut;
  logic sdaHostOeN;
  logic sdaDevOut;
  logic sdaDevOeN;
  logic sda;

  // Wired-AND data line with a pull-up: a released end leaves it high.
  assign sda = (sdaHostOeN | sdaHostOut) & (sdaDevOeN | sdaDevOut);

  modport device (
    input  scl,
    input  sda,
    output sdaDevOut,
    output sdaDevOeN
  );
  modport host (
    output scl,
    input  sda,
    output sdaHostOut,
    output sdaHostOeN
  );
endinterface

// ---- src/lnb_host_master.sv ----
// Host end: bus master that writes the single control register.
`timescale 1ns/10ps
`include "lnb_ctrl_defines.svh"
module lnb_host_master #(
  parameter int QuarterCyc    = `SCL_QUARTER_CYC,
  parameter int RestartGapCyc = `RESTART_GAP_CYC
) (
  input  wire logic       clk,
  input  wire logic       srst,
  lnb_link_if.host        link,
  input  wire logic       reqValid,
  input  wire logic [6:0] reqAddr,
  input  wire logic [7:0] reqData,
  output logic            busy,
  output logic            done,
  output logic            acked
);

  lnb_ctrl_pkg::host_s q;
  lnb_ctrl_pkg::host_s d;
  logic                tick;
  logic                gapBlock;

  assign tick     = (q.qCnt == 8'(QuarterCyc - 1));
  assign gapBlock = reqData[`CTRL_ENABLE_BIT] && (q.gapCnt != 25'h000_0000);

  // ----------------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;
    d.done = 1'b0;
    d.sdaS1 = link.sda;
    d.sdaS2 = q.sdaS1;
    d.qCnt = (q.st == lnb_ctrl_pkg::HOST_IDLE || tick) ? 8'h00 : q.qCnt + 8'h01;
    if (q.gapCnt != 25'h000_0000) begin
      d.gapCnt = q.gapCnt - 25'h000_0001;
    end
    if (tick) begin
      d.quarter = q.quarter + 2'h1;
    end
    case (q.st)
      lnb_ctrl_pkg::HOST_IDLE: begin
        if (reqValid && !gapBlock) begin
          d.st = lnb_ctrl_pkg::HOST_START;
          d.quarter = 2'h0;
          d.frame = {reqAddr, 1'b0, 1'b1, `CTRL_REG_ADDR, 1'b1, reqData, 1'b1};
          d.bitIdx = 5'h00;
          d.bitInByte = 4'h0;
          d.nak = 1'b0;
          d.busy = 1'b1;
          d.enReq = reqData[`CTRL_ENABLE_BIT];
        end
      end
      lnb_ctrl_pkg::HOST_START: begin
        if (tick) begin
          if (q.quarter == 2'h0) begin
            d.sdaOeN = 1'b0;
          end else begin
            d.scl = 1'b0;
            d.quarter = 2'h0;
            d.st = lnb_ctrl_pkg::HOST_BIT;
          end
        end
      end
      lnb_ctrl_pkg::HOST_BIT: begin
        if (tick) begin
          case (q.quarter)
            2'h0: begin
              d.sdaOeN = q.frame[26];
            end
            2'h1: begin
              d.scl = 1'b1;
            end
            2'h2: begin
              if (q.bitInByte == `ACK_BIT_POS && q.sdaS2) begin
                d.nak = 1'b1;
              end
            end
            default: begin
              d.scl = 1'b0;
              d.frame = {q.frame[25:0], 1'b1};
              d.bitIdx = q.bitIdx + 5'h01;
              d.bitInByte = (q.bitInByte == `ACK_BIT_POS) ? 4'h0 : q.bitInByte + 4'h1;
              if ((q.bitInByte == `ACK_BIT_POS && q.nak) || q.bitIdx == `FRAME_LAST_BIT) begin
                d.st = lnb_ctrl_pkg::HOST_STOP;
              end
            end
          endcase
        end
      end
      lnb_ctrl_pkg::HOST_STOP: begin
        if (tick) begin
          case (q.quarter)
            2'h0: d.sdaOeN = 1'b0;
            2'h1: d.scl = 1'b1;
            2'h2: d.sdaOeN = 1'b1;
            default: begin
              d.st = lnb_ctrl_pkg::HOST_IDLE;
              d.busy = 1'b0;
              d.done = 1'b1;
              d.acked = ~q.nak;
              if (q.enReq && !q.nak) begin
                d.gapCnt = 25'(RestartGapCyc);
              end
            end
          endcase
        end
      end
      default: d.st = lnb_ctrl_pkg::HOST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.st <= lnb_ctrl_pkg::HOST_IDLE;
      q.scl <= 1'b1;
      q.sdaOeN <= 1'b1;
      q.sdaS1 <= 1'b1;
      q.sdaS2 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign link.scl        = q.scl;
  assign link.sdaHostOut = 1'b0;
  assign link.sdaHostOeN = q.sdaOeN;
  assign busy            = q.busy;
  assign done            = q.done;
  assign acked           = q.acked;

endmodule

// ---- bench/lnb_link_checker.sv ----
// Checker of the shared two-wire lines between host and device.
`timescale 1ns/10ps
module lnb_link_checker #(
  parameter logic [6:0] DevAddr = 7'h08
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sdaHostOut,
  input wire logic sdaHostOeN,
  input wire logic sdaDevOut,
  input wire logic sdaDevOeN
);
  typedef struct packed {
    logic       sclPrev;
    logic       sdaPrev;
    logic       ok;
    logic [4:0] cnt;
    logic [7:0] sh;
  } mon_s;
  mon_s mon_q, mon_d;
  logic rise, start, stop, slot, expAck;
  assign rise = scl && !mon_q.sclPrev;
  assign start = scl && mon_q.sclPrev && !sda && mon_q.sdaPrev;
  assign stop = scl && mon_q.sclPrev && sda && !mon_q.sdaPrev;
  assign slot = mon_q.cnt == 5'h08 || mon_q.cnt == 5'h11 || mon_q.cnt == 5'h1a;
  // The data byte is acked on the earlier bytes alone; its value is free.
  assign expAck = mon_q.cnt == 5'h08 ? mon_q.sh == {DevAddr, 1'b0}
                : mon_q.ok && (mon_q.cnt == 5'h1a || mon_q.sh == 8'h00);
  always_comb begin
    mon_d = mon_q;
    mon_d.sclPrev = scl;
    mon_d.sdaPrev = sda;
    if (start) begin
      mon_d.cnt = 5'h00;
      mon_d.ok = 1'b1;
    end else if (rise) begin
      mon_d.cnt = mon_q.cnt + 5'h01;
      mon_d.sh = {mon_q.sh[6:0], sda};
      if (slot) begin
        mon_d.ok = expAck;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      mon_q <= {2'b11, 14'h0000};
    end else begin
      mon_q <= mon_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence ackSlot;
    rise && slot;
  endsequence
  sequence devAck;
    rise && slot && !sda;
  endsequence
  sequence startSeq;
    scl && sda ##1 scl && !sda;
  endsequence
  open_drain_a: assert property (!sdaDevOut && !sdaHostOut)
    else $error("data pin driven high");
  dev_clk_low_a: assert property (!$stable(sdaDevOeN) |-> !scl)
    else $error("device data moved while clock high");
  host_stable_a: assert property (
    scl && $past(scl) && !$stable(sdaHostOeN) |-> !$stable(sda))
    else $error("host data moved while clock high");
  ack_value_a: assert property (ackSlot |-> sda == !expAck)
    else $error("wrong acknowledge level");
  ack_hold_a: assert property (devAck |-> (!sdaDevOeN) [*8])
    else $error("acknowledge not held");
  host_release_a: assert property (ackSlot |-> sdaHostOeN)
    else $error("host drives acknowledge slot");
  reg_zero_a: assert property (rise && mon_q.cnt > 5'h08 && mon_q.cnt < 5'h11 |-> !sda)
    else $error("register byte not zero");
  frame_len_a: assert property (stop && mon_q.ok |-> mon_q.cnt == 5'h1c)
    else $error("acked write has wrong length");
  start_hold_a: assert property (startSeq |-> scl [*4])
    else $error("clock fell too soon after start");
endmodule

// ---- bench/tb.sv ----
// Bench: host and device joined, plus a second device driven pin by pin.
`timescale 1ns/10ps
`include "lnb_ctrl_defines.svh"
module tb;
  localparam logic [6:0] Addr = {`SLAVE_ADDR_HI, 2'b01};
  localparam int Boost = `BOOST_DIV_CYC;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        reqValid = 1'b0;
  logic [6:0]  reqAddr = 7'h00;
  logic [7:0]  reqData = 8'h00;
  logic        toneGate = 1'b0;
  logic        limit = 1'b0;
  logic        ovr = 1'b0;
  logic [1:0]  sel2 = 2'b01;
  logic        busy, done, acked, boostClk, toneOut, pullDown, regOn, fault;
  logic [7:0]  ctrl, ctrl2;
  logic [27:0] cap = 28'h000_0000;
  logic        sclLast = 1'b1;
  logic [6:0]  bad [4] = '{7'h08, 7'h0a, 7'h0b, 7'h19};
  int          failures = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          c;
  lnb_link_if link ();
  lnb_link_if link2 ();
  lnb_host_master #(.QuarterCyc(8), .RestartGapCyc(200)) lnb_host_master_i (
    .clk(clk), .srst(srst), .link(link), .reqValid(reqValid), .reqAddr(reqAddr),
    .reqData(reqData), .busy(busy), .done(done), .acked(acked));
  lnb_regulator_control_logic #(.OcTimeoutTicks(20)) lnb_regulator_control_logic_i (
    .clk(clk), .srst(srst), .link(link), .addrSel(2'b01), .toneGate(toneGate),
    .currentLimitActive(limit), .outputOverdrive(ovr), .boostClk(boostClk),
    .toneOut(toneOut), .pullDownStrong(pullDown), .regulatorOn(regOn),
    .overcurrentFaultFlag(fault), .controlWord(ctrl));
  lnb_regulator_control_logic #(.OcTimeoutTicks(20)) lnb_regulator_control_logic_i2 (
    .clk(clk), .srst(srst), .link(link2), .addrSel(sel2), .toneGate(toneGate),
    .currentLimitActive(limit), .outputOverdrive(ovr), .boostClk(), .toneOut(),
    .pullDownStrong(), .regulatorOn(), .overcurrentFaultFlag(), .controlWord(ctrl2));
  lnb_link_checker #(.DevAddr(Addr)) lnb_link_checker_i (
    .clk(clk), .srst(srst), .scl(link.scl), .sda(link.sda), .sdaHostOut(link.sdaHostOut),
    .sdaHostOeN(link.sdaHostOeN), .sdaDevOut(link.sdaDevOut), .sdaDevOeN(link.sdaDevOeN));
  always #25 clk = ~clk;
  // Every bit sampled on the host link; the stop's clock rise shifts in one more.
  always @(posedge clk) begin
    sclLast <= link.scl;
    if (link.scl && !sclLast) begin
      cap <= {cap[26:0], link.sda};
    end
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures = failures + 1;
      summarize();
    end
  end
  task automatic summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [27:0] e, input logic [27:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic e);
    int n;
    n = 0;
    reqValid = 1'b1;
    reqAddr = a;
    reqData = d;
    tk(1);
    reqValid = 1'b0;
    while (done !== 1'b1 && n < 2000) begin
      tk(1);
      n++;
    end
    chk("done", 1'b1, done);
    chk("acked", e, acked);
  endtask
  // Counts clocks from one rising edge to the next; zero if it never toggles.
  task automatic per(input logic s, output int p);
    logic v, l;
    int k;
    p = 0;
    k = 0;
    l = 1'b1;
    repeat (2000) begin
      tk(1);
      v = s ? toneOut : boostClk;
      if (v && !l) k++;
      if (k == 1) p++;
      l = v;
    end
  endtask
  // Second link: bit 1 is the data release, bit 0 the clock level.
  task automatic pin(input logic [1:0] v);
    link2.sdaHostOeN = v[1];
    link2.scl = v[0];
    tk(8);
  endtask
  task automatic strt();
    pin(2'b10);
    pin(2'b11);
    pin(2'b01);
    pin(2'b00);
  endtask
  task automatic stp();
    pin(2'b00);
    pin(2'b01);
    pin(2'b11);
  endtask
  task automatic sbyte(input logic [7:0] d, input logic e);
    for (int i = 7; i >= 0; i--) begin
      pin({d[i], 1'b0});
      pin({d[i], 1'b1});
      pin({d[i], 1'b0});
    end
    pin(2'b10);
    pin(2'b11);
    chk("ack2", e, link2.sda);
    pin(2'b10);
  endtask
  initial begin
    link2.scl = 1'b1;
    link2.sdaHostOut = 1'b0;
    link2.sdaHostOeN = 1'b1;
    tk(20);
    srst = 1'b0;
    tk(3);
    chk("idle", 2'b11, {link.scl, link.sda});
    chk("ctrl", 8'h00, ctrl);
    wr(Addr, 8'h01, 1'b1);
    chk("frame", {Addr, 2'b00, 8'h00, 1'b0, 8'h01, 2'b00}, cap);
    chk("ctrl", 8'h01, ctrl);
    chk("on", 1'b1, regOn);
    foreach (bad[i]) begin
      wr(bad[i], 8'h00, 1'b0);
      chk("ctrl", 8'h01, ctrl);
    end
    per(1'b0, c);
    chk("boost", Boost, c);
    per(1'b1, c);
    chk("toneOff", 0, c);
    chk("pull", 1'b0, pullDown);
    toneGate = 1'b1;
    tk(6);
    chk("pull", 1'b1, pullDown);
    per(1'b1, c);
    chk("tone", Boost * `TONE_BOOST_RATIO, c);
    limit = 1'b1;
    tk(15 * Boost);
    limit = 1'b0;
    tk(6);
    limit = 1'b1;
    tk(15 * Boost);
    chk("fault", 1'b0, fault);
    tk(10 * Boost);
    chk("fault", 1'b1, fault);
    chk("on", 1'b0, regOn);
    limit = 1'b0;
    tk(100);
    chk("on", 1'b0, regOn);
    wr(Addr, 8'h01, 1'b1);
    chk("fault", 1'b0, fault);
    // A second enable this soon must be dropped by the host.
    reqValid = 1'b1;
    tk(1);
    reqValid = 1'b0;
    tk(2);
    chk("busy", 1'b0, busy);
    ovr = 1'b1;
    tk(6);
    chk("on", 1'b0, regOn);
    ovr = 1'b0;
    tk(6);
    chk("on", 1'b1, regOn);
    wr(Addr, 8'h00, 1'b1);
    chk("ctrl", 8'h00, ctrl);
    strt();
    sbyte({Addr, 1'b0}, 1'b0);
    sbyte(8'h00, 1'b0);
    repeat (4) begin
      pin(2'b10);
      pin(2'b11);
      pin(2'b10);
    end
    strt();
    sbyte({Addr, 1'b0}, 1'b0);
    sbyte(8'h00, 1'b0);
    sbyte(8'h80, 1'b0);
    sbyte(8'h55, 1'b1);
    stp();
    chk("ctrl2", 8'h80, ctrl2);
    strt();
    sbyte({Addr, 1'b1}, 1'b1);
    sbyte(8'h00, 1'b1);
    stp();
    strt();
    sbyte({Addr, 1'b0}, 1'b0);
    sbyte(8'h01, 1'b1);
    stp();
    chk("ctrl2", 8'h80, ctrl2);
    // The select pins move the second device to another address.
    sel2 = 2'b10;
    tk(4);
    strt();
    sbyte({`SLAVE_ADDR_HI, 2'b10, 1'b0}, 1'b0);
    sbyte(8'h00, 1'b0);
    sbyte(8'h41, 1'b0);
    stp();
    chk("ctrl2", 8'h41, ctrl2);
    strt();
    sbyte({Addr, 1'b0}, 1'b1);
    sbyte(8'h00, 1'b1);
    stp();
    chk("ctrl2", 8'h41, ctrl2);
    summarize();
  end
endmodule
